/* design/foh_params.svh */
/*
  Register map, field positions, reset values and timing counts
  for the framing overhead octet ports. Assumes a 25 MHz aclk.
*/
`ifndef FOH_PARAMS_SVH
`define FOH_PARAMS_SVH
`define FOH_CFG_IDX 8'h01
`define FOH_CFG_ADDR (`FOH_CFG_IDX << 2)
`define FOH_ERR_ADDR 8'h08
`define FOH_STAT_ADDR 8'h0C
`define FOH_CFG_RST 16'h0000
`define FOH_ERR_RST 8'h00
`define FOH_MODE_LSB 0
`define FOH_C2_LSB 3
`define FOH_G1EN_BIT 5
`define FOH_HDLC_BIT 6
`define FOH_EXT_BIT 15
`define FOH_B3ONE_BIT 0
`define FOH_B3ZERO_BIT 1
`define FOH_REI1_BIT 2
`define FOH_REI0_BIT 3
`define FOH_RDI_BIT 4
`define FOH_QUAL_LSB 5
`define FOH_C2_INT 8'h13
`define FOH_OCT_ZERO 8'h00
`define FOH_RESP_OK 2'h0
`define FOH_RESP_ERR 2'h2
`define FOH_CLK_NS 40
`define FOH_STB_NS 120
`define FOH_STB_CYC ((`FOH_STB_NS + `FOH_CLK_NS - 1) / `FOH_CLK_NS)
`define FOH_LEN_STS1 12'h05A
`define FOH_LEN_STS3 12'h10E
`define FOH_LEN_E3 12'h219
`define FOH_LEN_E4 12'h870
`define FOH_OH_STS1 12'h004
`define FOH_OH_STS3 12'h00A
`define FOH_OH_E3 12'h007
`define FOH_OH_E4 12'h010
`define FOH_ROWS_SONET 4'h9
`define FOH_GC_IDX 12'h006
`endif

/* design/foh_pkg.sv */
/*
  Types for the framing overhead octet ports.
  Assumes foh_params.svh supplies all numeric constants.
*/
package foh_pkg;
  typedef enum logic [2:0] {FOH_STS1, FOH_STS3C, FOH_E3_G832,
    FOH_E4_G832, FOH_DS3, FOH_E3_G751} foh_mode_e;
  typedef enum logic [1:0] {STB_IDLE, STB_SETUP, STB_HIGH} foh_stb_e;
  typedef struct packed {
    foh_stb_e ph;
    logic [1:0] cnt;
  } foh_stb_s;
  typedef struct packed {
    logic [11:0] col;
    logic [3:0] row;
  } foh_pos_s;
  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic aw_hold;
    logic w_hold;
    logic [7:0] addr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
  } foh_axi_s;
  typedef struct packed {
    logic strobe;
    logic marker;
    logic [7:0] octet;
    logic oh_ext;
    logic oh_valid;
  } foh_txo_s;
  typedef struct packed {
    logic [1:0] strobe;
    logic [1:0] marker;
    logic [7:0] bus;
    logic [7:0] hdlc_octet;
    logic hdlc_valid;
    logic hdlc_bit;
    logic hdlc_bit_valid;
  } foh_rxo_s;
  typedef struct packed {
    foh_axi_s axi;
    logic [15:0] cfg;
    logic [7:0] errp;
    logic [2:0] tck;
    logic [2:0] rck;
    logic [7:0] td1;
    logic [7:0] td2;
    logic [7:0] rd1;
    logic [7:0] rd2;
    logic [7:0] ob1;
    logic [7:0] ob2;
    logic [1:0] tfs;
    logic [1:0] rfs;
    logic [1:0] rpoh;
    logic [1:0] rj1;
    foh_pos_s tpos;
    foh_pos_s rpos;
    foh_pos_s tslot;
    foh_stb_s tst;
    foh_stb_s rst1;
    foh_stb_s rst0;
    logic [7:0] b3_acc;
    logic [7:0] b3_prev;
    logic [15:0] tfr;
    logic [15:0] rfr;
    foh_txo_s tx;
    foh_rxo_s rx;
  } foh_state_s;
endpackage

/* design/foh_octet_ports.sv */
/*
  Framing overhead octet ports: transmit overhead port with path
  overhead generation, receive overhead port, HDLC octet taps and an
  AXI4-Lite register slave. Assumes line clocks, line data and frame
  syncs come from outside the aclk domain, with line clock periods of
  at least eight aclk cycles; hdlc, rei and data-link inputs are on aclk.
*/
// What this block does
// - E2, J1, F2, Z3, Z4, Z5 always come from the external bus.
// - B3 parity computed and inserted; single error or all-zero forcing.
// - C2 is 0x00 disabled, 0x13 internal, or external bus octet.
// - G1 carries REI count or forced ones/zeros, RDI, qualifier; else 0x00.
// - transmit port: strobe, marker, 8-bit input bus in SONET/G.832 modes.
// - one strobe per overhead octet; bus taken at strobe falling edge.
// - external-enable bit 15 of config 0x01 takes every octet externally.
// - STS-1: four strobes per row, 36 per frame, marker on row one.
// - STS-3c/STM-1: same, ten strobes per row, 90 per frame.
// - D1-D3 from HDLC formatter when enabled, else from external bus.
// - E3 seven, E4 sixteen strobes per frame; marker on FA1 and FA2.
// - receive port: two strobes, two markers, 8-bit output bus.
// - strobe one for section/line or G.832 octets; strobe zero path.
// - markers and bus set up before strobe rising edge.
// - marker one high for A1, A2, C1 or FA1, FA2.
// - marker zero high for J1 in SONET/SDH modes.
// - receive octets per frame: 36, 90, 7 and 16.
// - received D1-D3 and GC octets go to HDLC receiver.
// - DS3 C-bit data link and G.751 N-bit go to HDLC receiver.
`timescale 1ns/10ps
`include "foh_params.svh"
module foh_octet_ports
  import foh_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic awvalid,
  output logic awready,
  input wire logic [7:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  input wire logic arvalid,
  output logic arready,
  input wire logic [7:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  input wire logic tx_line_clk,
  input wire logic [7:0] tx_line_data,
  input wire logic tx_frame_sync,
  input wire logic [7:0] tx_ovh_in_bus,
  input wire logic [7:0] hdlc_tx_octet,
  input wire logic [3:0] path_rei_count,
  output logic tx_ovh_strobe,
  output logic tx_row1_marker,
  output logic [7:0] tx_oh_octet,
  output logic tx_oh_ext,
  output logic tx_oh_valid,
  input wire logic rx_line_clk,
  input wire logic [7:0] rx_line_data,
  input wire logic rx_frame_sync,
  input wire logic rx_poh_slot,
  input wire logic rx_j1_mark,
  input wire logic tdl_bit,
  input wire logic tdl_valid,
  output logic [1:0] rx_ovh_strobes,
  output logic [1:0] rx_row1_markers,
  output logic [7:0] rx_ovh_out_bus,
  output logic [7:0] hdlc_rx_octet,
  output logic hdlc_rx_valid,
  output logic hdlc_rx_bit,
  output logic hdlc_rx_bit_valid
);
  localparam logic [1:0] STB_LAST = 2'(`FOH_STB_CYC - 1);

  foh_state_s s_r;
  foh_state_s s_nxt;

  function automatic logic is_sonet(foh_mode_e m);
    return (m == FOH_STS1) || (m == FOH_STS3C);
  endfunction

  function automatic logic [11:0] oh_cnt(foh_mode_e m);
    case (m)
      FOH_STS1: return `FOH_OH_STS1;
      FOH_STS3C: return `FOH_OH_STS3;
      FOH_E3_G832: return `FOH_OH_E3;
      FOH_E4_G832: return `FOH_OH_E4;
      default: return 12'h000;
    endcase
  endfunction

  function automatic logic [11:0] row_len(foh_mode_e m);
    case (m)
      FOH_STS1: return `FOH_LEN_STS1;
      FOH_STS3C: return `FOH_LEN_STS3;
      FOH_E3_G832: return `FOH_LEN_E3;
      FOH_E4_G832: return `FOH_LEN_E4;
      default: return `FOH_LEN_STS1;
    endcase
  endfunction

  // STS-3c interleaves three octets per overhead column group
  function automatic logic [1:0] grp(foh_mode_e m, logic [11:0] c);
    if (m != FOH_STS3C)
      return c[1:0];
    else if (c >= 12'h006)
      return 2'h2;
    else if (c >= 12'h003)
      return 2'h1;
    else
      return 2'h0;
  endfunction

  function automatic logic last_slot(foh_pos_s p, foh_mode_e m);
    logic [3:0] rows;
    rows = is_sonet(m) ? `FOH_ROWS_SONET : 4'h1;
    return (p.col == row_len(m) - 12'h001) && (p.row == rows - 4'h1);
  endfunction

  function automatic foh_pos_s adv(foh_pos_s p, foh_mode_e m);
    foh_pos_s q;
    q = p;
    if (last_slot(p, m))
      q = '0;
    else if (p.col == row_len(m) - 12'h001)
    begin
      q.col = 12'h000;
      q.row = p.row + 4'h1;
    end
    else
      q.col = p.col + 12'h001;
    return q;
  endfunction

  function automatic foh_stb_s stb_step(foh_stb_s st, logic go);
    foh_stb_s q;
    q = st;
    unique case (st.ph)
      STB_IDLE:
      begin
        if (go)
          q.ph = STB_SETUP;
      end
      STB_SETUP:
      begin
        q.ph = STB_HIGH;
        q.cnt = 2'h0;
      end
      STB_HIGH:
      begin
        if (st.cnt == STB_LAST)
          q.ph = STB_IDLE;
        else
          q.cnt = st.cnt + 2'h1;
      end
    endcase
    return q;
  endfunction

  always_comb
  begin
    foh_state_s n;
    foh_mode_e md;
    foh_pos_s slot;
    logic sn;
    logic ext_all;
    logic hdlc_en;
    logic t_rise;
    logic r_rise;
    logic t_fall;
    logic t_go;
    logic r1_go;
    logic r0_go;
    logic poh;
    logic [1:0] g;
    logic [3:0] rei;
    logic [7:0] v;
    logic x;
    logic [11:0] ohc;
    n = s_r;
    md = foh_mode_e'(s_r.cfg[`FOH_MODE_LSB +: 3]);
    sn = is_sonet(md);
    ohc = oh_cnt(md);
    ext_all = s_r.cfg[`FOH_EXT_BIT];
    hdlc_en = s_r.cfg[`FOH_HDLC_BIT];
    slot = '0;
    g = 2'h0;
    rei = 4'h0;
    v = `FOH_OCT_ZERO;
    x = 1'b0;
    poh = 1'b0;
    t_go = 1'b0;
    r1_go = 1'b0;
    r0_go = 1'b0;
    // first stage of each synchroniser feeds only the second
    n.tck = {s_r.tck[1:0], tx_line_clk};
    n.rck = {s_r.rck[1:0], rx_line_clk};
    n.td1 = tx_line_data;
    n.td2 = s_r.td1;
    n.rd1 = rx_line_data;
    n.rd2 = s_r.rd1;
    n.ob1 = tx_ovh_in_bus;
    n.ob2 = s_r.ob1;
    n.tfs = {s_r.tfs[0], tx_frame_sync};
    n.rfs = {s_r.rfs[0], rx_frame_sync};
    n.rpoh = {s_r.rpoh[0], rx_poh_slot};
    n.rj1 = {s_r.rj1[0], rx_j1_mark};
    t_rise = s_r.tck[1] & ~s_r.tck[2];
    r_rise = s_r.rck[1] & ~s_r.rck[2];
    n.tx.oh_valid = 1'b0;
    n.rx.hdlc_valid = 1'b0;
    n.rx.hdlc_bit_valid = 1'b0;

    if (t_rise)
    begin
      slot = s_r.tfs[1] ? '0 : s_r.tpos;
      n.tpos = adv(slot, md);
      if (sn && slot.col >= ohc - 12'h001)
        n.b3_acc = s_r.b3_acc ^ s_r.td2;
      if (last_slot(slot, md))
      begin
        n.b3_prev = n.b3_acc;
        n.b3_acc = `FOH_OCT_ZERO;
        n.tfr = s_r.tfr + 16'h0001;
      end
      if (slot.col < ohc)
      begin
        t_go = 1'b1;
        n.tslot = slot;
        n.tx.marker = sn ? (slot.row == 4'h0) : (slot.col < 12'h002);
      end
    end
    t_fall = (s_r.tst.ph == STB_HIGH) && (s_r.tst.cnt == STB_LAST);
    n.tst = stb_step(s_r.tst, t_go);
    n.tx.strobe = (n.tst.ph == STB_HIGH);

    // bus taken as the strobe falls
    if (t_fall)
    begin
      v = s_r.ob2;
      x = 1'b1;
      poh = sn && (s_r.tslot.col == ohc - 12'h001);
      g = grp(md, s_r.tslot.col);
      if (sn && !poh)
      begin
        if (s_r.tslot.row == 4'h2 && hdlc_en && !ext_all)
        begin
          v = hdlc_tx_octet;
          x = 1'b0;
        end
        // framer-generated octets unless external enabled
        else if (s_r.tslot.row == 4'h0 || s_r.tslot.row == 4'h3 ||
                 s_r.tslot.row == 4'h4 ||
                 (s_r.tslot.row == 4'h1 && g == 2'h0) ||
                 (s_r.tslot.row == 4'h8 && g != 2'h2))
          x = ext_all;
      end
      // J1, F2, Z3-Z5 fall through to the bus
      else if (poh && !ext_all)
      begin
        case (s_r.tslot.row)
          4'h1:
          begin
            if (s_r.errp[`FOH_B3ZERO_BIT])
              v = `FOH_OCT_ZERO;
            else
              v = s_r.b3_prev ^ {7'h00, s_r.errp[`FOH_B3ONE_BIT]};
            n.errp[`FOH_B3ONE_BIT] = 1'b0;
            x = 1'b0;
          end
          4'h2:
          begin
            x = s_r.cfg[`FOH_C2_LSB +: 2] > 2'h1;
            if (s_r.cfg[`FOH_C2_LSB +: 2] == 2'h0)
              v = `FOH_OCT_ZERO;
            else if (s_r.cfg[`FOH_C2_LSB +: 2] == 2'h1)
              v = `FOH_C2_INT;
          end
          4'h3:
          begin
            if (s_r.errp[`FOH_REI1_BIT])
              rei = 4'hF;
            else if (s_r.errp[`FOH_REI0_BIT])
              rei = 4'h0;
            else
              rei = path_rei_count;
            v = {rei, s_r.errp[`FOH_RDI_BIT],
                 s_r.errp[`FOH_QUAL_LSB +: 2], 1'b0};
            if (!s_r.cfg[`FOH_G1EN_BIT])
              v = `FOH_OCT_ZERO;
            x = 1'b0;
          end
          4'h5:
          begin
            v = `FOH_OCT_ZERO;
            x = 1'b0;
          end
          default:
            x = 1'b1;
        endcase
      end
      else if (!sn)
      begin
        if (s_r.tslot.col == `FOH_GC_IDX && hdlc_en && !ext_all)
        begin
          v = hdlc_tx_octet;
          x = 1'b0;
        end
        else if (s_r.tslot.col < 12'h003)
          x = ext_all;
      end
      n.tx.octet = v;
      n.tx.oh_ext = x;
      n.tx.oh_valid = 1'b1;
    end

    if (r_rise)
    begin
      slot = s_r.rfs[1] ? '0 : s_r.rpos;
      n.rpos = adv(slot, md);
      if (last_slot(slot, md))
        n.rfr = s_r.rfr + 16'h0001;
      // section/line or G.832 octets on strobe one
      if (slot.col < (sn ? ohc - 12'h001 : ohc))
      begin
        r1_go = 1'b1;
        // bus and marker ahead of the strobe
        n.rx.bus = s_r.rd2;
        n.rx.marker[1] = sn ? (slot.row == 4'h0) : (slot.col < 12'h002);
        if ((sn && slot.row == 4'h2) || (!sn && slot.col == `FOH_GC_IDX))
        begin
          n.rx.hdlc_octet = s_r.rd2;
          n.rx.hdlc_valid = 1'b1;
        end
      end
      else if (sn && s_r.rpoh[1])
      begin
        r0_go = 1'b1;
        n.rx.bus = s_r.rd2;
        n.rx.marker[0] = s_r.rj1[1];
      end
    end
    n.rst1 = stb_step(s_r.rst1, r1_go);
    n.rst0 = stb_step(s_r.rst0, r0_go);
    // two strobes beside markers and bus
    n.rx.strobe = {n.rst1.ph == STB_HIGH, n.rst0.ph == STB_HIGH};

    if ((md == FOH_DS3 || md == FOH_E3_G751) && tdl_valid)
    begin
      n.rx.hdlc_bit = tdl_bit;
      n.rx.hdlc_bit_valid = 1'b1;
    end

    // register slave: address and data may arrive in either order
    if (awvalid && s_r.axi.awready)
    begin
      n.axi.aw_hold = 1'b1;
      n.axi.addr = awaddr;
    end
    if (wvalid && s_r.axi.wready)
    begin
      n.axi.w_hold = 1'b1;
      n.axi.wdata = wdata;
      n.axi.wstrb = wstrb;
    end
    if (s_r.axi.bvalid && bready)
      n.axi.bvalid = 1'b0;
    if (s_r.axi.aw_hold && s_r.axi.w_hold && !s_r.axi.bvalid)
    begin
      n.axi.aw_hold = 1'b0;
      n.axi.w_hold = 1'b0;
      n.axi.bvalid = 1'b1;
      n.axi.bresp = `FOH_RESP_OK;
      // software write lands after the hardware clear, so it wins
      if (s_r.axi.addr == `FOH_CFG_ADDR)
      begin
        if (s_r.axi.wstrb[0])
          n.cfg[7:0] = s_r.axi.wdata[7:0];
        if (s_r.axi.wstrb[1])
          n.cfg[15:8] = s_r.axi.wdata[15:8];
      end
      else if (s_r.axi.addr == `FOH_ERR_ADDR)
      begin
        if (s_r.axi.wstrb[0])
          n.errp = s_r.axi.wdata[7:0];
      end
      else if (s_r.axi.addr != `FOH_STAT_ADDR)
        n.axi.bresp = `FOH_RESP_ERR;
    end
    n.axi.awready = !n.axi.aw_hold && !n.axi.bvalid;
    n.axi.wready = !n.axi.w_hold && !n.axi.bvalid;

    if (s_r.axi.rvalid && rready)
      n.axi.rvalid = 1'b0;
    if (arvalid && s_r.axi.arready)
    begin
      n.axi.rvalid = 1'b1;
      n.axi.rresp = `FOH_RESP_OK;
      n.axi.rdata = 32'h0000_0000;
      if (araddr == `FOH_CFG_ADDR)
        n.axi.rdata[15:0] = s_r.cfg;
      else if (araddr == `FOH_ERR_ADDR)
        n.axi.rdata[7:0] = n.errp;
      else if (araddr == `FOH_STAT_ADDR)
        n.axi.rdata = {s_r.rfr, s_r.tfr};
      else
        n.axi.rresp = `FOH_RESP_ERR;
    end
    n.axi.arready = !n.axi.rvalid;
    s_nxt = n;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_r <= '0;
      s_r.cfg <= `FOH_CFG_RST;
      s_r.errp <= `FOH_ERR_RST;
    end
    else if (ce)
      s_r <= s_nxt;
  end

  assign awready = s_r.axi.awready;
  assign wready = s_r.axi.wready;
  assign bvalid = s_r.axi.bvalid;
  assign bresp = s_r.axi.bresp;
  assign arready = s_r.axi.arready;
  assign rvalid = s_r.axi.rvalid;
  assign rdata = s_r.axi.rdata;
  assign rresp = s_r.axi.rresp;
  assign tx_ovh_strobe = s_r.tx.strobe;
  assign tx_row1_marker = s_r.tx.marker;
  assign tx_oh_octet = s_r.tx.octet;
  assign tx_oh_ext = s_r.tx.oh_ext;
  assign tx_oh_valid = s_r.tx.oh_valid;
  assign rx_ovh_strobes = s_r.rx.strobe;
  assign rx_row1_markers = s_r.rx.marker;
  assign rx_ovh_out_bus = s_r.rx.bus;
  assign hdlc_rx_octet = s_r.rx.hdlc_octet;
  assign hdlc_rx_valid = s_r.rx.hdlc_valid;
  assign hdlc_rx_bit = s_r.rx.hdlc_bit;
  assign hdlc_rx_bit_valid = s_r.rx.hdlc_bit_valid;
endmodule

/* verification/foh_octet_ports_properties.sv */
/* Timing checks on the overhead port outputs.
   Assumes binding into foh_octet_ports on aclk. */
`timescale 1ns/10ps
module foh_ports_chk
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic tx_ovh_strobe,
  input wire logic tx_row1_marker,
  input wire logic tx_oh_valid,
  input wire logic [1:0] rx_ovh_strobes,
  input wire logic [1:0] rx_row1_markers,
  input wire logic [7:0] rx_ovh_out_bus,
  input wire logic tdl_bit,
  input wire logic tdl_valid,
  input wire logic hdlc_rx_bit,
  input wire logic hdlc_rx_bit_valid
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_tx_len;
    $rose(tx_ovh_strobe) |-> tx_ovh_strobe[*3] ##1 !tx_ovh_strobe;
  endproperty
  a_tx_len: assert property (p_tx_len) else $error("tx strobe width");
  property p_tx_val;
    $fell(tx_ovh_strobe) |-> tx_oh_valid;
  endproperty
  a_tx_val: assert property (p_tx_val) else $error("tx octet late");
  // line clock is at least eight cycles, so a gap must follow
  property p_tx_gap;
    $fell(tx_ovh_strobe) |-> !tx_ovh_strobe[*3];
  endproperty
  a_tx_gap: assert property (p_tx_gap) else $error("tx strobe gap");
  property p_tx_mk;
    $rose(tx_ovh_strobe) |-> $stable(tx_row1_marker);
  endproperty
  a_tx_mk: assert property (p_tx_mk) else $error("tx marker late");
  property p_rx_len;
    $rose(rx_ovh_strobes[1]) |->
      rx_ovh_strobes[1][*3] ##1 !rx_ovh_strobes[1];
  endproperty
  a_rx_len: assert property (p_rx_len) else $error("rx strobe width");
  property p_rx_one;
    rx_ovh_strobes != 2'h3;
  endproperty
  a_rx_one: assert property (p_rx_one) else $error("rx both strobes");
  property p_rx_set;
    $rose(|rx_ovh_strobes) |->
      $stable(rx_ovh_out_bus) && $stable(rx_row1_markers);
  endproperty
  a_rx_set: assert property (p_rx_set) else $error("rx setup");
  property p_rx_hold;
    |rx_ovh_strobes |=> $stable(rx_ovh_out_bus);
  endproperty
  a_rx_hold: assert property (p_rx_hold) else $error("rx hold");
  property p_dl;
    hdlc_rx_bit_valid |-> $past(tdl_valid) && hdlc_rx_bit == $past(tdl_bit);
  endproperty
  a_dl: assert property (p_dl) else $error("data link bit");
  c_txm: cover property ($rose(tx_ovh_strobe) && tx_row1_marker);
  c_j1: cover property ($rose(rx_ovh_strobes[0]) && rx_row1_markers[0]);
  c_dl: cover property (hdlc_rx_bit_valid);
endmodule
bind foh_octet_ports foh_ports_chk u_foh_ports_chk (.aclk, .aresetn,
  .tx_ovh_strobe, .tx_row1_marker, .tx_oh_valid, .rx_ovh_strobes,
  .rx_row1_markers, .rx_ovh_out_bus, .tdl_bit, .tdl_valid,
  .hdlc_rx_bit, .hdlc_rx_bit_valid);

/* verification/foh_ovh_partner.sv */
/* Far-side overhead logic: free line clock, frame position,
   octet supply and per-frame strobe counts.
   Assumes aclk of 40 ns; line clock of 320 ns. */
`timescale 1ns/10ps
`include "foh_params.svh"
module foh_ovh_partner
  import foh_pkg::*;
(
  input wire logic aclk,
  input wire logic restart,
  input wire logic [2:0] mode,
  output logic lclk,
  output logic [7:0] ldata,
  output logic fsync,
  output logic poh,
  output logic j1,
  output logic [7:0] obus,
  input wire logic tstb,
  input wire logic tmk,
  input wire logic [1:0] rstb,
  input wire logic [1:0] rmk,
  input wire logic hvld,
  output logic [7:0] sup,
  output logic [15:0] tslot,
  output logic [7:0] rtag,
  output logic [55:0] fcnt,
  output int nfr
);
  logic [11:0] col, ncol, pcol;
  logic [3:0] row, nrow;
  logic [15:0] cur;
  logic [55:0] cnt;
  initial
  begin
    {ldata, fsync, poh, j1, obus, sup, tslot, rtag, cur} = '0;
    {col, row, cnt, fcnt, ncol, nrow, pcol} = '0;
    lclk = 1'b1;
    nfr = 0;
  end
  always #160 lclk = ~lclk;
  // data set half a period early so it is stable at the rise
  always @(negedge lclk)
  begin
    case (mode)
      FOH_STS3C: {ncol, nrow} = {`FOH_LEN_STS3, `FOH_ROWS_SONET};
      FOH_E3_G832: {ncol, nrow} = {`FOH_LEN_E3, 4'h1};
      FOH_E4_G832: {ncol, nrow} = {`FOH_LEN_E4, 4'h1};
      default: {ncol, nrow} = {`FOH_LEN_STS1, `FOH_ROWS_SONET};
    endcase
    pcol = (mode == FOH_STS3C) ? `FOH_OH_STS3 - 12'h001 : 3'h3;
    if (restart)
      {col, row} = '0;
    fsync = {col, row} == '0;
    poh = mode < 3'h2 && col == pcol;
    j1 = poh && row == 4'h0;
    ldata = {row, col[3:0]} ^ 8'hC3;
  end
  always @(posedge lclk)
  begin
    if (fsync)
    begin
      fcnt = cnt;
      cnt = '0;
      nfr = nfr + 1;
    end
    cur = {row, col};
    rtag = ldata;
    col = col + 12'h001;
    if (col == ncol)
    begin
      col = '0;
      row = (row + 4'h1 == nrow) ? 4'h0 : row + 4'h1;
    end
  end
  always @(posedge tstb)
  begin
    sup = {cur[15:12], cur[3:0]} ^ 8'h96;
    obus = sup;
    tslot = cur;
    cnt[7:0] += 8'h01;
    cnt[15:8] += {7'h00, tmk};
  end
  // held three cycles past the fall, then driven to garbage
  always @(negedge tstb)
  begin
    repeat (3) @(posedge aclk);
    #1 obus = ~obus;
  end
  always @(posedge rstb[1])
  begin
    cnt[23:16] += 8'h01;
    cnt[39:32] += {7'h00, rmk[1]};
  end
  always @(posedge rstb[0])
  begin
    cnt[31:24] += 8'h01;
    cnt[47:40] += {7'h00, rmk[0]};
  end
  always @(posedge hvld) cnt[55:48] += 8'h01;
endmodule

/* verification/foh_octet_ports_tb.sv */
/* Self-checking bench: register access, per-mode frame counts,
   path octet sources, data link bits.
   Assumes foh_ovh_partner for the line side. */
`timescale 1ns/10ps
`include "foh_params.svh"
module foh_octet_ports_tb;
  logic aclk, aresetn, ce, awvalid, awready, wvalid, wready, bvalid;
  logic bready, arvalid, arready, rvalid, rready, restart;
  logic [7:0] awaddr, araddr, tx_line_data, rx_line_data, tx_ovh_in_bus;
  logic [7:0] hdlc_tx_octet, tx_oh_octet, rx_ovh_out_bus, hdlc_rx_octet;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb, path_rei_count;
  logic [1:0] bresp, rresp, rx_ovh_strobes, rx_row1_markers;
  logic tx_line_clk, tx_frame_sync, tx_ovh_strobe, tx_row1_marker;
  logic tx_oh_ext, tx_oh_valid, rx_line_clk, rx_frame_sync, rx_poh_slot;
  logic rx_j1_mark, tdl_bit, tdl_valid, hdlc_rx_valid, hdlc_rx_bit;
  logic hdlc_rx_bit_valid;
  logic [2:0] pmode;
  logic [7:0] sup, rtag;
  logic [15:0] tslot;
  logic [55:0] fcnt, ec;
  logic [9:0] te;
  int nfr, chk, err_total, n_compared;
  localparam logic [55:0] EXPC [4] = '{56'h030103091B0424,
    56'h09010909510A5A, 56'h01000200070207, 56'h01000200100210};
  foh_octet_ports u_foh_octet_ports (.*);
  foh_ovh_partner u_foh_ovh_partner (.aclk, .restart, .mode(pmode),
    .lclk(tx_line_clk), .ldata(tx_line_data), .fsync(tx_frame_sync),
    .poh(rx_poh_slot), .j1(rx_j1_mark), .obus(tx_ovh_in_bus),
    .tstb(tx_ovh_strobe), .tmk(tx_row1_marker), .rstb(rx_ovh_strobes),
    .rmk(rx_row1_markers), .hvld(hdlc_rx_valid), .sup, .tslot, .rtag,
    .fcnt, .nfr);
  assign rx_line_clk = tx_line_clk;
  assign rx_line_data = tx_line_data;
  assign rx_frame_sync = tx_frame_sync;
  always #20 aclk = ~aclk;
  task cmp(input logic [31:0] g, input logic [31:0] e);
  begin
    n_compared++;
    if (g !== e)
    begin
      err_total++;
      $display("BAD t=%0t got %h exp %h", $time, g, e);
    end
  end
  endtask
  task end_sim;
  begin
    $display("compared %0d bad %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  end
  endtask
  task axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    int n;
  begin
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    n = 0;
    do
    begin
      @(posedge aclk);
      if (awready)
        awvalid <= 1'b0;
      if (wready)
        wvalid <= 1'b0;
      n++;
    end
    while (!bvalid && n < 100);
    if (!bvalid)
      err_total++;
    bready <= 1'b0;
    cmp(bresp, r);
  end
  endtask
  task axr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    int n;
  begin
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    n = 0;
    do
    begin
      @(posedge aclk);
      if (arready)
        arvalid <= 1'b0;
      n++;
    end
    while (!rvalid && n < 100);
    if (!rvalid)
      err_total++;
    rready <= 1'b0;
    cmp(rdata, d);
    cmp(rresp, r);
  end
  endtask
  // line side realigned so a whole frame is counted
  task frame(input logic [15:0] cf, input logic [7:0] ep, input int k);
    int n0, n;
  begin
    axw(`FOH_ERR_ADDR, {24'h0, ep}, `FOH_RESP_OK);
    axw(`FOH_CFG_ADDR, {16'h0, cf}, `FOH_RESP_OK);
    pmode <= cf[2:0];
    restart <= 1'b1;
    repeat (10) @(posedge aclk);
    restart <= 1'b0;
    repeat (10) @(posedge aclk);
    n0 = nfr;
    chk = k;
    n = 0;
    while (nfr == n0 && n < 25000)
    begin
      @(posedge aclk);
      n++;
    end
    if (n == 25000)
      err_total++;
    chk = 0;
    $display("frame test cfg %h done", cf);
  end
  endtask
  function automatic logic [9:0] exp_tx(input int k, input logic [15:0] s,
    input logic [7:0] x);
  begin
    exp_tx = '0;
    if (k == 1)
      exp_tx = {2'h3, x};
    else if (s[11:0] == 12'h003)
      case (s[15:12])
        4'h1: exp_tx = {2'h2, `FOH_OCT_ZERO};
        4'h2: exp_tx = {2'h2, `FOH_C2_INT};
        4'h3: exp_tx = {2'h2, 4'hF, 1'b1, 2'h1, 1'b0};
        4'h5: exp_tx = '0;
        default: exp_tx = {2'h3, x};
      endcase
    else if (s[11:0] < 12'h003 && s[15:12] == 4'h2)
      exp_tx = {2'h2, hdlc_tx_octet};
  end
  endfunction
  always @(posedge aclk)
    if (chk != 0 && tx_oh_valid)
    begin
      te = exp_tx(chk, tslot, sup);
      if (te[9])
        cmp({tx_oh_ext, tx_oh_octet}, te[8:0]);
    end
  always @(posedge rx_ovh_strobes[1] or posedge rx_ovh_strobes[0])
    cmp(rx_ovh_out_bus, rtag);
  always @(posedge aclk)
    if (hdlc_rx_valid)
      cmp(hdlc_rx_octet, rtag);
  initial
  begin
    {aclk, aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
    {restart, pmode, awaddr, araddr, wdata, tdl_bit, tdl_valid} = '0;
    {err_total, n_compared, chk} = '0;
    ce = 1'b1;
    wstrb = 4'hF;
    hdlc_tx_octet = 8'h5C;
    path_rei_count = 4'h9;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    axr(`FOH_CFG_ADDR, 32'h0, `FOH_RESP_OK);
    axr(`FOH_ERR_ADDR, 32'h0, `FOH_RESP_OK);
    axr(8'h10, 32'h0, `FOH_RESP_ERR);
    axw(8'h10, 32'hFFFF, `FOH_RESP_ERR);
    axw(`FOH_CFG_ADDR, 32'h8001, `FOH_RESP_OK);
    axr(`FOH_CFG_ADDR, 32'h8001, `FOH_RESP_OK);
    axw(`FOH_STAT_ADDR, 32'h0, `FOH_RESP_OK);
    $display("register test done");
    for (int m = 0; m < 4; m++)
    begin
      frame(16'h8000 | m[15:0], 8'h00, 1);
      ec = EXPC[m];
      for (int i = 0; i < 7; i++)
        cmp(fcnt[8*i+:8], ec[8*i+:8]);
    end
    frame(16'h0068, 8'h36, 2);
    frame(16'h0004, 8'h00, 0);
    cmp(fcnt[31:0], 32'h0);
    for (int m = 4; m < 6; m++)
    begin
      axw(`FOH_CFG_ADDR, m, `FOH_RESP_OK);
      tdl_bit <= ~m[0];
      tdl_valid <= 1'b1;
      @(posedge aclk);
      tdl_valid <= 1'b0;
      #1 cmp({hdlc_rx_bit_valid, hdlc_rx_bit}, {1'b1, ~m[0]});
      @(posedge aclk);
    end
    $display("data link test done");
    end_sim;
  end
  initial
  begin
    #3600000;
    err_total++;
    end_sim;
  end
endmodule
